// ---- rtl/rcc_reset_combiner.sv ----
// module: reset source combiner with cause register and interrupt
`timescale 1ns/1ps

module rcc_reset_combiner (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire rcc_pkg::rcc_src_s i_src,
    input wire logic i_sleep_wake,
    input wire logic i_idle_wake,
    input wire logic i_watchdog_fuse_enable,
    input wire rcc_pkg::rcc_bus_s i_bus,
    output logic [rcc_pkg::DW-1:0] o_rdata,
    output logic o_system_reset_out,
    output logic o_watchdog_run,
    output logic o_regulator_standby_sel,
    output logic o_irq
);
    import rcc_pkg::*;

    rcc_state_s st_r;
    rcc_state_s st_nxt;
    logic [DW-1:0] flag_set;
    logic any_src;

    // register index match, used by write and read decode
    function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
        hit = (a == off);
    endfunction

    // map active sources and wake pulses onto cause bit positions
    function automatic logic [DW-1:0] src_flags(input rcc_src_s s,
                                                input logic slp, input logic idl);
        logic [DW-1:0] f;
        f = ZERO_W;
        f[B_TRAP] = s.trap_conflict;
        f[B_OPC] = s.illegal_opcode | s.uninit_wreg_source;
        f[B_CFG] = s.cfg_mismatch;
        f[B_PIN] = s.master_clear_pin;
        f[B_SOFT] = s.reset_instr;
        f[B_WATCHDOG_TIMEOUT_FLAG] = s.watchdog_timeout;
        f[B_SLEEP] = slp;
        f[B_IDLE] = idl;
        f[B_BOR] = s.brownout | s.power_on;
        f[B_POR] = s.power_on;
        src_flags = f;
    endfunction

    // system reset is the plain OR of every source
    assign any_src = |i_src;
    assign flag_set = src_flags(i_src, i_sleep_wake, i_idle_wake);

    // next state: power-on dominates, hardware sets win over software writes
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = ZERO_W;
        if (i_bus.wr && hit(i_bus.addr, OFF_CAUSE)) begin
            st_nxt.cause = i_bus.wdata & CAUSE_IMPL;
        end
        if (i_bus.wr && hit(i_bus.addr, OFF_IMASK)) begin
            st_nxt.imask = i_bus.wdata & CAUSE_IMPL;
        end
        if (i_bus.rd) begin
            if (hit(i_bus.addr, OFF_CAUSE)) begin
                st_nxt.rdata = st_r.cause;
            end else if (hit(i_bus.addr, OFF_ISTAT)) begin
                st_nxt.rdata = st_r.istat;
                st_nxt.istat = ZERO_W; // read clears
            end else if (hit(i_bus.addr, OFF_IMASK)) begin
                st_nxt.rdata = st_r.imask;
            end
        end
        st_nxt.cause = st_nxt.cause | flag_set;
        st_nxt.istat = st_nxt.istat | flag_set;
        if (i_src.power_on) begin
            st_nxt.cause = CAUSE_POR_VAL;
        end
    end

    // state register; only i_srst, power-on and cause writes clear cause bits, other resets only set their own bits
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            st_r.cause <= CAUSE_RST;
            st_r.istat <= ISTAT_RST;
            st_r.imask <= IMASK_RST;
            st_r.rdata <= ZERO_W;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs
    assign o_rdata = st_r.rdata;
    assign o_system_reset_out = any_src;
    assign o_watchdog_run = i_watchdog_fuse_enable | st_r.cause[B_WDEN];
    assign o_regulator_standby_sel = st_r.cause[B_VREG];
    assign o_irq = |(st_r.istat & st_r.imask);

    // ---------------- checks ----------------

    sequence s_cause_write;
        i_bus.wr && hit(i_bus.addr, OFF_CAUSE) && !any_src
            && !i_sleep_wake && !i_idle_wake;
    endsequence

    sequence s_cause_read;
        i_bus.rd && hit(i_bus.addr, OFF_CAUSE);
    endsequence

    sequence s_istat_read;
        i_bus.rd && hit(i_bus.addr, OFF_ISTAT) && (flag_set == ZERO_W);
    endsequence

    reset_or_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (any_src |-> o_system_reset_out) and (!any_src |-> !o_system_reset_out))
        else $error("system reset does not follow sources");

    por_value_a: assert property (@(posedge i_clock) disable iff (i_srst)
        i_src.power_on |=> (st_r.cause == CAUSE_POR_VAL))
        else $error("power-on value wrong");

    trap_flag_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_src.trap_conflict && !i_src.power_on) |=> st_r.cause[B_TRAP])
        else $error("trap flag not set");

    opcode_flag_a: assert property (@(posedge i_clock) disable iff (i_srst)
        ((i_src.illegal_opcode || i_src.uninit_wreg_source) && !i_src.power_on)
            |=> st_r.cause[B_OPC])
        else $error("bad opcode flag not set");

    cfg_flag_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_src.cfg_mismatch && !i_src.power_on) |=> st_r.cause[B_CFG])
        else $error("config mismatch flag not set");

    bor_flag_a: assert property (@(posedge i_clock) disable iff (i_srst)
        i_src.brownout |=> st_r.cause[B_BOR])
        else $error("brown-out flag not set");

    wdt_flag_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_src.watchdog_timeout && !i_src.power_on) |=> st_r.cause[B_WATCHDOG_TIMEOUT_FLAG])
        else $error("watchdog flag not set");

    soft_flag_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_src.reset_instr && !i_src.power_on) |=> st_r.cause[B_SOFT])
        else $error("software reset flag not set");

    pin_flag_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_src.master_clear_pin && !i_src.power_on) |=> st_r.cause[B_PIN])
        else $error("pin reset flag not set");

    sleep_flag_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_sleep_wake && !i_src.power_on) |=> st_r.cause[B_SLEEP])
        else $error("sleep flag not set");

    write_store_a: assert property (@(posedge i_clock) disable iff (i_srst)
        s_cause_write |=> (st_r.cause == ($past(i_bus.wdata) & CAUSE_IMPL)))
        else $error("cause write not stored");

    write_noreset_a: assert property (@(posedge i_clock) disable iff (i_srst)
        s_cause_write ##1 !any_src |-> !o_system_reset_out)
        else $error("software write caused a reset");

    wdt_run_a: assert property (@(posedge i_clock) disable iff (i_srst)
        i_watchdog_fuse_enable |-> o_watchdog_run)
        else $error("watchdog stopped with fuse unprogrammed");

    cause_read_a: assert property (@(posedge i_clock) disable iff (i_srst)
        s_cause_read |=> (o_rdata == $past(st_r.cause)))
        else $error("cause read data wrong");

    istat_clear_a: assert property (@(posedge i_clock) disable iff (i_srst)
        s_istat_read |=> (st_r.istat == ZERO_W) && !o_irq)
        else $error("status read did not clear");

    sequence s_mask_write;
        i_bus.wr && hit(i_bus.addr, OFF_IMASK);
    endsequence

    sequence s_mask_read;
        i_bus.rd && hit(i_bus.addr, OFF_IMASK);
    endsequence

    sequence s_unmapped_read;
        i_bus.rd && !hit(i_bus.addr, OFF_CAUSE) && !hit(i_bus.addr, OFF_ISTAT)
            && !hit(i_bus.addr, OFF_IMASK);
    endsequence

    // synchronous reset loads the documented start values
    srst_value_a: assert property (@(posedge i_clock)
        i_srst |=> (st_r.cause == CAUSE_RST) && (st_r.istat == ISTAT_RST)
            && (st_r.imask == IMASK_RST) && (o_rdata == ZERO_W))
        else $error("reset values wrong");

    // power-on also raises the two low status bits
    por_status_a: assert property (@(posedge i_clock) disable iff (i_srst)
        i_src.power_on |=> (st_r.istat[B_BOR] && st_r.istat[B_POR]))
        else $error("power-on status bits not set");

    // idle wake is stored like the sleep flag
    idle_flag_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_idle_wake && !i_src.power_on) |=> st_r.cause[B_IDLE])
        else $error("idle flag not set");

    // unimplemented cause bits never become visible
    cause_unimpl_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (st_r.cause & ~CAUSE_IMPL) == ZERO_W)
        else $error("unimplemented cause bit set");

    // unimplemented mask bits never become visible
    mask_unimpl_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (st_r.imask & ~CAUSE_IMPL) == ZERO_W)
        else $error("unimplemented mask bit set");

    // mask write stores the implemented bits
    mask_store_a: assert property (@(posedge i_clock) disable iff (i_srst)
        s_mask_write |=> (st_r.imask == ($past(i_bus.wdata) & CAUSE_IMPL)))
        else $error("mask write not stored");

    // mask read returns the mask
    mask_read_a: assert property (@(posedge i_clock) disable iff (i_srst)
        s_mask_read |=> (o_rdata == $past(st_r.imask)))
        else $error("mask read data wrong");

    // unmapped read returns zero
    unmapped_read_a: assert property (@(posedge i_clock) disable iff (i_srst)
        s_unmapped_read |=> (o_rdata == ZERO_W))
        else $error("unmapped read not zero");

    // read data stands one cycle only
    rdata_idle_a: assert property (@(posedge i_clock) disable iff (i_srst)
        !i_bus.rd |=> (o_rdata == ZERO_W))
        else $error("read data not cleared");

    // status bits are sticky until a status read
    istat_hold_a: assert property (@(posedge i_clock) disable iff (i_srst)
        !(i_bus.rd && hit(i_bus.addr, OFF_ISTAT))
            |=> ((st_r.istat & $past(st_r.istat)) == $past(st_r.istat)))
        else $error("status bit lost");

    // an unmasked event raises the interrupt the next cycle
    irq_set_a: assert property (@(posedge i_clock) disable iff (i_srst)
        ((flag_set & st_r.imask) != ZERO_W) && !s_mask_write |=> o_irq)
        else $error("interrupt not raised");

    // trap event also lands in the status register
    trap_stat_a: assert property (@(posedge i_clock) disable iff (i_srst)
        i_src.trap_conflict |=> st_r.istat[B_TRAP])
        else $error("trap status not set");

    // bad opcode event also lands in the status register
    opcode_stat_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_src.illegal_opcode || i_src.uninit_wreg_source) |=> st_r.istat[B_OPC])
        else $error("bad opcode status not set");

    // mismatch event also lands in the status register
    cfg_stat_a: assert property (@(posedge i_clock) disable iff (i_srst)
        i_src.cfg_mismatch |=> st_r.istat[B_CFG])
        else $error("config mismatch status not set");

    // watchdog event also lands in the status register
    wdt_stat_a: assert property (@(posedge i_clock) disable iff (i_srst)
        i_src.watchdog_timeout |=> st_r.istat[B_WATCHDOG_TIMEOUT_FLAG])
        else $error("watchdog status not set");

    // reset instruction also lands in the status register
    soft_stat_a: assert property (@(posedge i_clock) disable iff (i_srst)
        i_src.reset_instr |=> st_r.istat[B_SOFT])
        else $error("software reset status not set");

    // pin reset also lands in the status register
    pin_stat_a: assert property (@(posedge i_clock) disable iff (i_srst)
        i_src.master_clear_pin |=> st_r.istat[B_PIN])
        else $error("pin reset status not set");

    // brown-out also lands in the status register
    bor_stat_a: assert property (@(posedge i_clock) disable iff (i_srst)
        i_src.brownout |=> st_r.istat[B_BOR])
        else $error("brown-out status not set");

    // each implemented flag holds unless written or power-on
    for (genvar g = 0; g < DW; g++) begin : g_hold
        if (CAUSE_IMPL[g]) begin : g_impl
            flag_hold_a: assert property (@(posedge i_clock) disable iff (i_srst)
                (st_r.cause[g] && !i_src.power_on
                    && !(i_bus.wr && hit(i_bus.addr, OFF_CAUSE)))
                    |=> st_r.cause[g])
                else $error("cause flag lost");
        end
    end

endmodule

// ---- rtl/rcc_pkg.sv ----
// package: constants, types and register map of the reset cause combiner
package rcc_pkg;

    localparam int AW = 4;
    localparam int DW = 16;

    // register indices on the plain register port
    localparam logic [AW-1:0] OFF_CAUSE = 4'h0;
    localparam logic [AW-1:0] OFF_ISTAT = 4'h1;
    localparam logic [AW-1:0] OFF_IMASK = 4'h2;

    // cause register bit positions
    localparam int B_TRAP = 15;
    localparam int B_OPC = 14;
    localparam int B_CFG = 9;
    localparam int B_VREG = 8;
    localparam int B_PIN = 7;
    localparam int B_SOFT = 6;
    localparam int B_WDEN = 5;
    localparam int B_WATCHDOG_TIMEOUT_FLAG = 4;
    localparam int B_SLEEP = 3;
    localparam int B_IDLE = 2;
    localparam int B_BOR = 1;
    localparam int B_POR = 0;

    // implemented bits, power-on value, reset values
    localparam logic [DW-1:0] CAUSE_IMPL = 16'hc3ff;
    localparam logic [DW-1:0] CAUSE_POR_VAL = 16'h0003;
    localparam logic [DW-1:0] CAUSE_RST = 16'h0003;
    localparam logic [DW-1:0] ISTAT_RST = 16'h0000;
    localparam logic [DW-1:0] IMASK_RST = 16'h0000;
    localparam logic [DW-1:0] ZERO_W = 16'h0000;

    // reset sources, active high levels
    typedef struct packed {
        logic master_clear_pin;
        logic power_on;
        logic brownout;
        logic watchdog_timeout;
        logic cfg_mismatch;
        logic reset_instr;
        logic trap_conflict;
        logic illegal_opcode;
        logic uninit_wreg_source;
    } rcc_src_s;

    // register port request
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic wr;
        logic rd;
    } rcc_bus_s;

    // whole state of the combiner
    typedef struct packed {
        logic [DW-1:0] cause;
        logic [DW-1:0] istat;
        logic [DW-1:0] imask;
        logic [DW-1:0] rdata;
    } rcc_state_s;

endpackage

// ---- bench/rcc_src_model.sv ----
// bench: model of the on-chip reset sources facing the combiner
`timescale 1ns/1ps

module rcc_src_model (
    input wire logic i_clock,
    output rcc_pkg::rcc_src_s o_src
);
    import rcc_pkg::*;

    // every source idle until a scenario raises one
    initial o_src = '0;

    // raise one source level for len cycles, then release it to idle
    task automatic fire(input int idx, input int len);
        @(posedge i_clock);
        o_src <= rcc_src_s'(9'h001 << idx);
        repeat (len) @(posedge i_clock);
        o_src <= '0;
    endtask
endmodule

// ---- bench/tb_reset_cause_combiner.sv ----
// bench: self-checking testbench of the reset cause combiner
`timescale 1ns/1ps

module tb_reset_cause_combiner;
    import rcc_pkg::*;

    logic i_clock = 1'b0;
    logic i_srst = 1'b1;
    logic sleep_wake = 1'b0;
    logic idle_wake = 1'b0;
    logic fuse_en = 1'b0;
    rcc_bus_s bus = '0;
    rcc_src_s src;
    logic [DW-1:0] rdata;
    logic sys_rst, wd_run, reg_sel, irq;
    logic rd_d_r = 1'b0;
    logic [DW-1:0] exp_q[$];
    logic [DW-1:0] d;
    int errors = 0;
    int cmp_count = 0;
    int seed = 13515;
    // expected cause bits per source, index equals the bit of the source struct
    logic [DW-1:0] exp_tab [9] = '{16'h4000, 16'h4000, 16'h8000, 16'h0040, 16'h0200,
                                   16'h0010, 16'h0002, 16'h0003, 16'h0080};

    // 100 MHz clock
    always #5 i_clock = ~i_clock;

    rcc_reset_combiner uut (
        .i_clock(i_clock), .i_srst(i_srst), .i_src(src), .i_sleep_wake(sleep_wake),
        .i_idle_wake(idle_wake), .i_watchdog_fuse_enable(fuse_en), .i_bus(bus),
        .o_rdata(rdata), .o_system_reset_out(sys_rst), .o_watchdog_run(wd_run),
        .o_regulator_standby_sel(reg_sel), .o_irq(irq)
    );

    rcc_src_model src_model (.i_clock(i_clock), .o_src(src));

    // compare one value and count it
    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe on the register port
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] w);
        @(posedge i_clock);
        bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
        @(posedge i_clock);
        bus <= '0;
    endtask

    // one-cycle read strobe; expected data queued for the monitor
    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge i_clock);
        bus <= '{addr: a, wdata: ZERO_W, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
        @(posedge i_clock);
        bus <= '0;
    endtask

    task automatic print_verdict;
        if (errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // monitor: read data in the cycle after the strobe, reset output every cycle once i_srst is released
    always @(posedge i_clock) begin
        rd_d_r <= bus.rd;
        if (rd_d_r) chk(rdata, exp_q.pop_front());
        if (!i_srst) chk({15'h0000, sys_rst}, {15'h0000, |src});
    end

    // hang guard
    initial begin
        repeat (5000) @(posedge i_clock);
        errors++;
        print_verdict();
    end

    // main sequence
    initial begin
        repeat (4) @(posedge i_clock);
        i_srst <= 1'b0;
        rd(OFF_CAUSE, CAUSE_RST);
        rd(OFF_ISTAT, ISTAT_RST);
        rd(OFF_IMASK, IMASK_RST);
        // every source alone, sticky after release, interrupt unmasked
        wr(OFF_IMASK, 16'hffff);
        for (int i = 0; i < 9; i++) begin
            wr(OFF_CAUSE, ZERO_W);
            src_model.fire(i, 1 + ($unsigned($random(seed)) % 3));
            #1 chk({15'h0000, irq}, 16'h0001);
            rd(OFF_ISTAT, exp_tab[i]);
            rd(OFF_CAUSE, exp_tab[i]);
        end
        #1 chk({15'h0000, irq}, 16'h0000);
        // masked event keeps the interrupt low
        wr(OFF_IMASK, ZERO_W);
        wr(OFF_CAUSE, ZERO_W);
        src_model.fire(2, 1);
        #1 chk({15'h0000, irq}, 16'h0000);
        rd(OFF_ISTAT, 16'h8000);
        // sleep and idle wake flags
        @(posedge i_clock);
        sleep_wake <= 1'b1;
        idle_wake <= 1'b1;
        @(posedge i_clock);
        sleep_wake <= 1'b0;
        idle_wake <= 1'b0;
        rd(OFF_CAUSE, 16'h800c);
        // random software writes store only, never reset
        repeat (6) begin
            d = $random(seed);
            wr(OFF_CAUSE, d);
            rd(OFF_CAUSE, d & CAUSE_IMPL);
            fuse_en <= d[0];
            #1 chk({15'h0000, wd_run}, {15'h0000, d[0] | d[B_WDEN]});
            chk({15'h0000, reg_sel}, {15'h0000, d[B_VREG]});
        end
        // status not writable, unmapped address reads zero
        wr(OFF_ISTAT, 16'hffff);
        wr(4'h5, 16'hffff);
        rd(OFF_ISTAT, 16'h000c); // sleep and idle status still pending, writes ignored
        rd(4'h5, ZERO_W);
        // power-on clears everything but the two low flags, mask kept
        wr(OFF_CAUSE, 16'hc3f0);
        wr(OFF_IMASK, 16'h0001);
        src_model.fire(7, 2);
        #1 chk({15'h0000, irq}, 16'h0001);
        rd(OFF_CAUSE, CAUSE_POR_VAL);
        rd(OFF_IMASK, 16'h0001);
        repeat (3) @(posedge i_clock);
        print_verdict();
    end
endmodule
